/* File: rtl/itcp_dev.sv */
// Target end of the two-wire configuration port: eight byte-wide control registers
// reached through address match, subaddress and auto-increment.
// Assumes a free-running link clock several times faster than the bus clock; both bus
// lines are sampled through two flip-flops before any logic looks at them.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "itcp_map.svh"

// How it works
// - Target only; never starts a transfer itself.
// - Answers bus address 0x70 plus direction bit.
// - Direction one reads, zero writes.
// - Start is data falling with clock high.
// - Acknowledge matched address and every in-range subaddress or data byte.
// - Address mismatch releases bus, waits in idle.
// - Data rising with clock high is stop.
// - Start or stop anywhere restarts or idles.
// - Controller: one condition per clock high.
// - Unknown subaddress: no acknowledge, back to idle.
// - Subaddress advances after every acknowledged data byte, stopping at the last register.
// - Read past end repeats the last register.
// - Write past end: discard, no acknowledge, idle.
// - Controller sets subaddress, then repeated start read.
// - Target sends read bytes; controller acknowledges, ends nack.
module itcp_dev (
  input wire logic link_clk_i,
  input wire logic resetn_i,
  output logic [63:0] regs_o,
  output logic busy_o,
  itcp_if.dev bus
);
  itcp_pkg::itcp_dev_type r;
  itcp_pkg::itcp_dev_type n;
  logic scl;
  logic sda;
  logic start;
  logic stop;
  logic rise;
  logic fall;

  assign scl = r.scl_sy[1];
  assign sda = r.sda_sy[1];
  assign rise = scl & ~r.scl_p;
  assign fall = ~scl & r.scl_p;
  // Both conditions need the clock high in this and the last sample, so a data edge that
  // races a clock edge is not mistaken for a condition.
  assign start = scl & r.scl_p & r.sda_p & ~sda;
  assign stop = scl & r.scl_p & ~r.sda_p & sda;

  always_comb
  begin
    n = r;
    n.scl_sy = {r.scl_sy[0], bus.scl};
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.scl_p = scl;
    n.sda_p = sda;
    if (stop)
    begin
      n.state = itcp_pkg::DS_IDLE;
      n.drive = 1'b0;
    end
    else if (start)
    begin
      // A start in any state, repeated or out of sequence, begins a fresh address byte.
      n.state = itcp_pkg::DS_ADDR;
      n.cnt = 4'h0;
      n.drive = 1'b0;
    end
    else
    begin
      case (r.state)
        itcp_pkg::DS_IDLE:
        begin
          n.drive = 1'b0;
        end
        itcp_pkg::DS_ADDR, itcp_pkg::DS_SUB, itcp_pkg::DS_WDATA:
        begin
          if (rise && r.cnt != 4'h8)
          begin
            n.sh = {r.sh[6:0], sda};
            n.cnt = r.cnt + 4'h1;
          end
          if (fall && r.cnt == 4'h8)
          begin
            n.cnt = 4'h0;
            n.state = itcp_pkg::DS_ACK;
            n.drive = 1'b1;
            case (r.state)
              itcp_pkg::DS_ADDR:
              begin
                if (r.sh[7:1] == `ITCP_DEV_ADDR)
                begin
                  n.after = r.sh[0] ? itcp_pkg::DS_RDATA : itcp_pkg::DS_SUB;
                end
                else
                begin
                  n.state = itcp_pkg::DS_IDLE;
                  n.drive = 1'b0;
                end
              end
              itcp_pkg::DS_SUB:
              begin
                if (r.sh < 8'(`ITCP_REG_NUM))
                begin
                  n.ptr = r.sh[2:0];
                  n.over = 1'b0;
                  n.after = itcp_pkg::DS_WDATA;
                end
                else
                begin
                  n.state = itcp_pkg::DS_IDLE;
                  n.drive = 1'b0;
                end
              end
              default:
              begin
                if (r.over)
                begin
                  // The byte beyond the last register is dropped and left unanswered.
                  n.state = itcp_pkg::DS_IDLE;
                  n.drive = 1'b0;
                end
                else
                begin
                  n.regs[r.ptr] = r.sh;
                  n.over = (r.ptr == `ITCP_REG_LAST);
                  if (r.ptr != `ITCP_REG_LAST)
                    n.ptr = r.ptr + 3'h1;
                  n.after = itcp_pkg::DS_WDATA;
                end
              end
            endcase
          end
        end
        itcp_pkg::DS_ACK:
        begin
          if (fall)
          begin
            n.drive = 1'b0;
            n.cnt = 4'h0;
            n.state = r.after;
            if (r.after == itcp_pkg::DS_RDATA)
            begin
              n.sh = r.regs[r.ptr];
              n.drive = ~r.regs[r.ptr][7];
            end
          end
        end
        itcp_pkg::DS_RDATA:
        begin
          if (rise)
            n.cnt = r.cnt + 4'h1;
          if (fall)
          begin
            if (r.cnt == 4'h8)
            begin
              // Release for the controller's acknowledge bit.
              n.drive = 1'b0;
              n.cnt = 4'h0;
              n.state = itcp_pkg::DS_RACK;
            end
            else
            begin
              n.sh = {r.sh[6:0], 1'b0};
              n.drive = ~r.sh[6];
            end
          end
        end
        itcp_pkg::DS_RACK:
        begin
          if (rise)
          begin
            n.nack = sda;
            // The pointer stops at the last register so a long burst keeps repeating it.
            if (!sda && r.ptr != `ITCP_REG_LAST)
              n.ptr = r.ptr + 3'h1;
          end
          if (fall)
          begin
            if (r.nack)
            begin
              n.state = itcp_pkg::DS_IDLE;
            end
            else
            begin
              n.state = itcp_pkg::DS_RDATA;
              n.sh = r.regs[r.ptr];
              n.drive = ~r.regs[r.ptr][7];
            end
          end
        end
        default:
        begin
          n.state = itcp_pkg::DS_IDLE;
          n.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    if (!resetn_i)
    begin
      r <= '0;
      r.scl_sy <= 2'h3;
      r.sda_sy <= 2'h3;
      r.regs <= `ITCP_RST_ALL;
    end
    else
    begin
      r <= n;
    end
  end

  assign regs_o = r.regs;
  assign busy_o = (r.state != itcp_pkg::DS_IDLE);
  // Open drain: the pad only ever pulls low.
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe_n = ~r.drive;
endmodule

/* File: rtl/itcp_map.svh */
// Constants of the two-wire configuration port: bus address, register map, reset values,
// controller register offsets and timing counts.
// Assumes nothing; included by both ends.
`ifndef ITCP_MAP_SVH
`define ITCP_MAP_SVH

`define ITCP_DEV_ADDR 7'h70
`define ITCP_REG_NUM 8
`define ITCP_REG_LAST 3'h7

`define ITCP_REG_POWER 3'h0
`define ITCP_REG_SYSFILT 3'h1
`define ITCP_REG_FMT_PRI 3'h2
`define ITCP_REG_FMT_SEC 3'h3
`define ITCP_REG_SLOT 3'h4
`define ITCP_REG_VOLUME 3'h5
`define ITCP_REG_GAIN 3'h6
`define ITCP_REG_FAULT 3'h7

`define ITCP_RST_POWER 8'h05
`define ITCP_RST_SYSFILT 8'h30
`define ITCP_RST_FMT_PRI 8'h02
`define ITCP_RST_FMT_SEC 8'h00
`define ITCP_RST_SLOT 8'h00
`define ITCP_RST_VOLUME 8'h40
`define ITCP_RST_GAIN 8'h11
`define ITCP_RST_FAULT 8'h0c
`define ITCP_RST_ALL {`ITCP_RST_FAULT, `ITCP_RST_GAIN, `ITCP_RST_VOLUME, `ITCP_RST_SLOT, \
  `ITCP_RST_FMT_SEC, `ITCP_RST_FMT_PRI, `ITCP_RST_SYSFILT, `ITCP_RST_POWER}

`define ITCP_CTL_CMD 4'h0
`define ITCP_CTL_TX 4'h4
`define ITCP_CTL_RX 4'h8
`define ITCP_CTL_STAT 4'hc

`define ITCP_CMD_START 0
`define ITCP_CMD_STOP 1
`define ITCP_CMD_READ 2
`define ITCP_CMD_NACK 3
`define ITCP_CMD_XFER 4
`define ITCP_STAT_BUSY 0
`define ITCP_STAT_NACK 1

`define ITCP_SYS_CLK_NS 10
`define ITCP_SCL_PERIOD_NS 10000
`define ITCP_QTR_CYC ((`ITCP_SCL_PERIOD_NS / 4 + `ITCP_SYS_CLK_NS - 1) / `ITCP_SYS_CLK_NS)

`endif

/* File: rtl/itcp_pkg.sv */
// Types shared by both ends of the two-wire configuration port.
// Assumes nothing; uses none of the constants header.
package itcp_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_SUB, DS_WDATA, DS_ACK, DS_RDATA, DS_RACK} itcp_dev_state_type;

  typedef enum logic [1:0] {CS_IDLE, CS_START, CS_BYTE, CS_STOP} itcp_ctl_state_type;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_p;
    logic sda_p;
    itcp_dev_state_type state;
    itcp_dev_state_type after;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [2:0] ptr;
    logic over;
    logic nack;
    logic drive;
    logic [7:0][7:0] regs;
  } itcp_dev_type;

  typedef struct packed {
    logic [1:0] sda_sy;
    itcp_ctl_state_type state;
    logic [1:0] ph;
    logic [15:0] tick;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic xfer;
    logic stop;
    logic read;
    logic nack_send;
    logic nack_seen;
    logic scl_low;
    logic sda_low;
    logic [7:0] rdata;
  } itcp_ctl_type;
endpackage

/* File: rtl/itcp_if.sv */
// Two-wire bus between the controller end and the target end.
// Both lines are open drain with a pull-up; the wire levels are resolved here from the enables.
`timescale 1ns/1ps
interface itcp_if;
  logic scl;
  logic sda;
  logic c_scl_o;
  logic c_scl_oe_n;
  logic c_sda_o;
  logic c_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;

  assign scl = c_scl_oe_n ? 1'b1 : c_scl_o;
  assign sda = (c_sda_oe_n ? 1'b1 : c_sda_o) & (d_sda_oe_n ? 1'b1 : d_sda_o);

  modport ctl (input sda, output c_scl_o, output c_scl_oe_n, output c_sda_o, output c_sda_oe_n);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface

/* File: rtl/itcp_ctl.sv */
// Controller end of the two-wire configuration port: makes the bus clock by a divider and
// runs start, byte and stop phases ordered through a small register port.
// Assumes software issues only legal bus sequences; the target never holds the clock low, as the clock line is not watched.
`timescale 1ns/1ps
`include "itcp_map.svh"
module itcp_ctl #(
  parameter int unsigned QTR = `ITCP_QTR_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic busy_o,
  itcp_if.ctl bus
);
  itcp_pkg::itcp_ctl_type r;
  itcp_pkg::itcp_ctl_type n;
  logic tick;
  logic sda;

  assign sda = r.sda_sy[1];
  assign tick = (r.tick == 16'(QTR - 1));

  always_comb
  begin
    n = r;
    n.sda_sy = {r.sda_sy[0], bus.sda};
    n.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `ITCP_CTL_TX: n.rdata = r.tx;
        `ITCP_CTL_RX: n.rdata = r.rx;
        `ITCP_CTL_STAT: n.rdata = {6'h00, r.nack_seen, r.state != itcp_pkg::CS_IDLE};
        default: n.rdata = 8'h00;
      endcase
    end
    if (r.state == itcp_pkg::CS_IDLE)
    begin
      n.tick = 16'h0000;
      n.ph = 2'h0;
      n.bitn = 4'h0;
      if (wr_i && addr_i == `ITCP_CTL_TX)
        n.tx = wdata_i;
      if (wr_i && addr_i == `ITCP_CTL_CMD)
      begin
        n.xfer = wdata_i[`ITCP_CMD_XFER];
        n.stop = wdata_i[`ITCP_CMD_STOP];
        n.read = wdata_i[`ITCP_CMD_READ];
        n.nack_send = wdata_i[`ITCP_CMD_NACK];
        if (wdata_i[`ITCP_CMD_START])
          n.state = itcp_pkg::CS_START;
        else if (wdata_i[`ITCP_CMD_XFER])
          n.state = itcp_pkg::CS_BYTE;
        else if (wdata_i[`ITCP_CMD_STOP])
          n.state = itcp_pkg::CS_STOP;
        else
          n.state = itcp_pkg::CS_IDLE;
      end
    end
    else
    begin
      n.tick = tick ? 16'h0000 : r.tick + 16'h0001;
      if (tick)
      begin
        n.ph = r.ph + 2'h1;
        case (r.state)
          itcp_pkg::CS_START:
          begin
            // Releasing data before raising the clock also serves as a repeated start.
            case (r.ph)
              2'h0: n.sda_low = 1'b0;
              2'h1: n.scl_low = 1'b0;
              2'h2: n.sda_low = 1'b1;
              default:
              begin
                n.scl_low = 1'b1;
                n.state = r.xfer ? itcp_pkg::CS_BYTE : (r.stop ? itcp_pkg::CS_STOP : itcp_pkg::CS_IDLE);
              end
            endcase
          end
          itcp_pkg::CS_BYTE:
          begin
            case (r.ph)
              2'h0:
              begin
                if (r.bitn == 4'h8)
                  n.sda_low = r.read & ~r.nack_send;
                else
                  n.sda_low = ~r.read & ~r.tx[7];
              end
              2'h1: n.scl_low = 1'b0;
              2'h2:
              begin
                if (r.bitn == 4'h8)
                  n.nack_seen = ~r.read & sda;
                else
                  n.rx = {r.rx[6:0], sda};
              end
              default:
              begin
                n.scl_low = 1'b1;
                n.bitn = r.bitn + 4'h1;
                if (r.bitn != 4'h8 && !r.read)
                  n.tx = {r.tx[6:0], 1'b0};
                if (r.bitn == 4'h8)
                begin
                  n.bitn = 4'h0;
                  n.state = r.stop ? itcp_pkg::CS_STOP : itcp_pkg::CS_IDLE;
                end
              end
            endcase
          end
          itcp_pkg::CS_STOP:
          begin
            case (r.ph)
              2'h0: n.sda_low = 1'b1;
              2'h1: n.scl_low = 1'b0;
              2'h2: n.sda_low = 1'b0;
              default: n.state = itcp_pkg::CS_IDLE;
            endcase
          end
          default: n.state = itcp_pkg::CS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      r <= '0;
    else
      r <= n;
  end

  assign rdata_o = r.rdata;
  assign busy_o = (r.state != itcp_pkg::CS_IDLE);
  assign bus.c_scl_o = 1'b0;
  assign bus.c_scl_oe_n = ~r.scl_low;
  assign bus.c_sda_o = 1'b0;
  assign bus.c_sda_oe_n = ~r.sda_low;
endmodule

/* File: test/itcp_chk_sva.sv */
// Checker for the two-wire bus between the controller end and the target end.
// Assumes the resolved wire levels and target enables of the interface, sampled on the link clock.
`timescale 1ns/1ps
module itcp_chk_sva (
  input wire logic link_clk_i,
  input wire logic resetn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n
);
  logic scl_q;
  logic sda_q;
  logic first_q;
  logic rdmode_q;
  logic [3:0] bitn_q;
  logic [7:0] hdr_q;
  wire rise = scl & ~scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;

  // Bits are counted from clock rises so the ninth pulse can be told apart from data bits.
  always_ff @(posedge link_clk_i)
  begin
    if (!resetn_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b0;
      rdmode_q <= 1'b0;
      bitn_q <= 4'h0;
      hdr_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        bitn_q <= 4'h0;
        first_q <= 1'b1;
      end
      else if (rise)
      begin
        if (bitn_q < 4'h8 && first_q)
          hdr_q <= {hdr_q[6:0], sda};
        bitn_q <= (bitn_q == 4'h8) ? 4'h0 : bitn_q + 4'h1;
        if (bitn_q == 4'h8)
        begin
          first_q <= 1'b0;
          if (first_q)
            rdmode_q <= hdr_q[0];
        end
      end
    end
  end

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_hdr_ninth;
    rise && bitn_q == 4'h8 && first_q;
  endsequence
  sequence s_data_bit;
    rise && bitn_q < 4'h8;
  endsequence

  property p_addr_ack;
    s_hdr_ninth ##0 (hdr_q[7:1] == 7'h70) |-> !sda;
  endproperty
  property p_addr_mis;
    s_hdr_ninth ##0 (hdr_q[7:1] != 7'h70) |-> sda;
  endproperty
  property p_no_cond;
    $changed(d_sda_oe_n) |-> !scl;
  endproperty
  property p_od;
    !d_sda_oe_n |-> !sda && !d_sda_o;
  endproperty
  property p_rd_rel;
    rise && bitn_q == 4'h8 && !first_q && rdmode_q |-> d_sda_oe_n;
  endproperty
  property p_wr_rel;
    s_data_bit ##0 (first_q || !rdmode_q) |-> d_sda_oe_n;
  endproperty
  property p_stop_rel;
    stop |=> d_sda_oe_n [*4];
  endproperty
  property p_start_rel;
    start |-> d_sda_oe_n [*3];
  endproperty

  a_addr_ack: assert property (p_addr_ack) else $error("no acknowledge of own address");
  a_addr_mis: assert property (p_addr_mis) else $error("foreign address acknowledged");
  a_no_cond: assert property (p_no_cond) else $error("target moved data while clock high");
  a_od: assert property (p_od) else $error("target drive not open drain");
  a_rd_rel: assert property (p_rd_rel) else $error("target held line in controller ack bit");
  a_wr_rel: assert property (p_wr_rel) else $error("target drove a controller data bit");
  a_stop_rel: assert property (p_stop_rel) else $error("target drove line after stop");
  a_start_rel: assert property (p_start_rel) else $error("target drove line at start");
endmodule

/* File: test/tb_i2c_target_config_port.sv */
// Testbench joining the controller end and the target end over the two-wire interface.
// Assumes both ends share one reset; the link clock runs free at 12 ns.
`timescale 1ns/1ps
module tb_i2c_target_config_port;
  logic sys_clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic busy_o;
  logic dev_busy;
  logic [63:0] regs_o;
  logic [7:0] st;
  logic [7:0] rx;
  int err_total = 0;
  int cmp_count = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  always #6 link_clk = ~link_clk;

  itcp_if bus_if ();
  // A short quarter period keeps the run brief; it stays far above the target's sync delay.
  itcp_ctl #(.QTR(25)) itcp_ctl_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o), .bus(bus_if));
  itcp_dev itcp_dev_i (.link_clk_i(link_clk), .resetn_i(resetn_i), .regs_o(regs_o), .busy_o(dev_busy),
    .bus(bus_if));
  itcp_chk_sva chk_i (.link_clk_i(link_clk), .resetn_i(resetn_i), .scl(bus_if.scl), .sda(bus_if.sda),
    .d_sda_o(bus_if.d_sda_o), .d_sda_oe_n(bus_if.d_sda_oe_n));

  task check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_o;
  endtask

  // One bus phase group: load the byte, order the command, wait for idle, collect status and data.
  task op(input logic [7:0] c, input logic [7:0] t);
    logic [7:0] s;
    int n;
    wr(4'h4, t);
    wr(4'h0, c);
    n = 0;
    do
    begin
      rd(4'hc, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      err_total++;
      conclude();
    end
    rd(4'hc, st);
    rd(4'h8, rx);
    check(busy_o, 1'b0);
  endtask

  task t_reset();
    check(regs_o, 64'h0c11_4000_0002_3005);
    check(bus_if.sda, 1'b1);
    rd(4'h2, rx);
    check(rx, 8'h00);
  endtask

  task t_write();
    op(8'h11, 8'he0);
    check(st[1], 1'b0);
    op(8'h10, 8'h05);
    check(st[1], 1'b0);
    op(8'h12, 8'ha5);
    check(st[1], 1'b0);
    check(regs_o, 64'h0c11_a500_0002_3005);
  endtask

  task t_burst();
    op(8'h11, 8'he0);
    op(8'h10, 8'h06);
    op(8'h10, 8'h5a);
    op(8'h10, 8'h3c);
    check(st[1], 1'b0);
    op(8'h12, 8'h77);
    check(st[1], 1'b1);
    check(regs_o, 64'h3c5a_a500_0002_3005);
  endtask

  task t_read();
    op(8'h11, 8'he0);
    op(8'h10, 8'h05);
    op(8'h11, 8'he1);
    check(st[1], 1'b0);
    op(8'h14, 8'hff);
    check(rx, 8'ha5);
    op(8'h14, 8'hff);
    check(rx, 8'h5a);
    op(8'h14, 8'hff);
    check(rx, 8'h3c);
    op(8'h14, 8'hff);
    check(rx, 8'h3c);
    op(8'h1e, 8'hff);
    check(rx, 8'h3c);
    check(dev_busy, 1'b0);
  endtask

  task t_refuse();
    op(8'h13, 8'he4);
    check(st[1], 1'b1);
    check(dev_busy, 1'b0);
    op(8'h11, 8'he0);
    op(8'h12, 8'h08);
    check(st[1], 1'b1);
    check(dev_busy, 1'b0);
    op(8'h11, 8'he0);
    op(8'h10, 8'h03);
    op(8'h11, 8'he0);
    check(st[1], 1'b0);
    op(8'h10, 8'h04);
    op(8'h12, 8'h66);
    check(regs_o, 64'h3c5a_a566_0002_3005);
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    t_reset();
    t_write();
    t_burst();
    t_read();
    t_refuse();
    conclude();
  end
endmodule
